// file: logic/sync_parallel_config_loader.sv
// Slave-parallel configuration loader: byte capture, acknowledge and daisy-chain serializer
`timescale 1ns/1ps
`include "sync_parallel_config_loader_regs.svh"

module sync_parallel_config_loader (
  // System clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Link clock, driven by the external controller
  input wire logic config_clock_i,
  // Mode-select pins
  input wire logic mode_select_msb_i,
  input wire logic mode_select_mid_i,
  input wire logic mode_select_lsb_i,
  // Initialization status pin, open drain
  input wire logic init_i,
  output logic init_o,
  output logic init_oe_o,
  // Parallel configuration data, synchronous to the link clock
  input wire logic [7:0] data_i,
  // Acknowledge pin
  output logic ack_o,
  output logic ack_oe_o,
  // Daisy-chain serial output
  output logic dout_o,
  // Status toward the rest of the device
  output logic config_done_o
);

  sync_parallel_config_loader_pkg::sys_regs_t sys_reg;
  sync_parallel_config_loader_pkg::sys_regs_t sys_next;
  sync_parallel_config_loader_pkg::link_regs_t link_reg;
  sync_parallel_config_loader_pkg::link_regs_t link_next;
  logic dout_reg;

  // Classifies a stream position as preamble, own configuration or overflow
  function automatic sync_parallel_config_loader_pkg::link_state_t stream_part(
    input logic [15:0] pos
  );
    sync_parallel_config_loader_pkg::link_state_t part;
    if (pos < `PREAMBLE_BITS) begin
      part = sync_parallel_config_loader_pkg::LINK_PREAMBLE;
    end else if (pos < 16'(`PREAMBLE_BITS + `OWN_CONFIG_BITS)) begin
      part = sync_parallel_config_loader_pkg::LINK_OWN;
    end else begin
      part = sync_parallel_config_loader_pkg::LINK_FORWARD;
    end
    return part;
  endfunction

  // Saturating increment of the stream bit counter
  function automatic logic [15:0] bit_inc(input logic [15:0] cnt);
    logic [15:0] res;
    res = cnt;
    if (cnt != 16'hffff) begin
      res = cnt + `BIT_CNT_ONE;
    end
    return res;
  endfunction

  // System domain: pin synchronizers, memory clear and load enable
  always_comb begin
    sys_next = sys_reg;
    sys_next.mode_meta = {mode_select_msb_i, mode_select_mid_i, mode_select_lsb_i};
    sys_next.mode_sync = sys_reg.mode_meta;
    sys_next.init_meta = init_i;
    sys_next.init_sync = sys_reg.init_meta;
    sys_next.done_meta = link_reg.loaded;
    sys_next.done_sync = sys_reg.done_meta;
    case (sys_reg.state)
      sync_parallel_config_loader_pkg::SYS_CLEAR: begin
        sys_next.init_drive = 1'b1;
        sys_next.load_en = 1'b0;
        if (sys_reg.clear_cnt == `CLEAR_CNT_ZERO) begin
          sys_next.init_drive = 1'b0;
          sys_next.state = sync_parallel_config_loader_pkg::SYS_WAIT_MODE;
        end else begin
          sys_next.clear_cnt = sys_reg.clear_cnt - `CLEAR_CNT_ONE;
        end
      end
      sync_parallel_config_loader_pkg::SYS_WAIT_MODE: begin
        // Wired-AND pin must be seen high before loading begins
        if (sys_reg.mode_sync == `MODE_SLAVE_PARALLEL && sys_reg.init_sync) begin
          sys_next.load_en = 1'b1;
          sys_next.state = sync_parallel_config_loader_pkg::SYS_LOADING;
        end
      end
      sync_parallel_config_loader_pkg::SYS_LOADING: begin
        if (sys_reg.mode_sync != `MODE_SLAVE_PARALLEL) begin
          sys_next.load_en = 1'b0;
          sys_next.state = sync_parallel_config_loader_pkg::SYS_WAIT_MODE;
        end else if (sys_reg.done_sync) begin
          sys_next.done = 1'b1;
          sys_next.state = sync_parallel_config_loader_pkg::SYS_DONE;
        end
      end
      sync_parallel_config_loader_pkg::SYS_DONE: begin
        sys_next.done = 1'b1;
        // Leaving the loading mode stops capture even after completion; done stays set
        if (sys_reg.mode_sync != `MODE_SLAVE_PARALLEL) begin
          sys_next.load_en = 1'b0;
        end
      end
      default: begin
        sys_next.state = sync_parallel_config_loader_pkg::SYS_CLEAR;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sys_reg <= '0;
      sys_reg.state <= sync_parallel_config_loader_pkg::SYS_CLEAR;
      sys_reg.clear_cnt <= `INIT_CLEAR_CYCLES;
      sys_reg.init_drive <= 1'b1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // Link domain: capture, acknowledge and serializer on the controller's clock
  always_comb begin
    link_next = link_reg;
    link_next.en_meta = sys_reg.load_en;
    link_next.en_sync = link_reg.en_meta;
    link_next.ack_drive = link_reg.en_sync;
    link_next.ack = 1'b0;
    if (!link_reg.en_sync) begin
      link_next.state = sync_parallel_config_loader_pkg::LINK_IDLE;
      link_next.started = 1'b0;
      link_next.phase = `BYTE_FIRST_BIT;
      link_next.shift = '0;
      link_next.bit_cnt = `BIT_CNT_ZERO;
      link_next.ser_bit = `DOUT_IDLE;
      link_next.loaded = 1'b0;
    end else begin
      // Bit leaving the shifter this edge, shown half a period later
      if (link_reg.started) begin
        link_next.state = stream_part(link_reg.bit_cnt);
        link_next.bit_cnt = bit_inc(link_reg.bit_cnt);
        if (stream_part(link_reg.bit_cnt) == sync_parallel_config_loader_pkg::LINK_OWN) begin
          link_next.ser_bit = `DOUT_IDLE;
        end else begin
          link_next.ser_bit = link_reg.shift[7];
        end
        if (stream_part(link_reg.bit_cnt) == sync_parallel_config_loader_pkg::LINK_FORWARD) begin
          link_next.loaded = 1'b1;
        end
      end
      if (link_reg.phase == `BYTE_FIRST_BIT) begin
        // First edge after enable and every eighth edge afterwards
        link_next.shift = data_i;
        link_next.ack = 1'b1;
        link_next.started = 1'b1;
        link_next.phase = link_reg.phase + 3'h1;
      end else begin
        link_next.shift = {link_reg.shift[6:0], 1'b0};
        if (link_reg.phase == `BYTE_LAST_BIT) begin
          link_next.phase = `BYTE_FIRST_BIT;
        end else begin
          link_next.phase = link_reg.phase + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge config_clock_i) begin
    link_reg <= link_next;
  end

  // Falling-edge stage for the next device downstream
  always_ff @(negedge config_clock_i) begin
    dout_reg <= link_reg.ser_bit;
  end

  // Outputs
  always_comb begin
    init_o = 1'b0;
    init_oe_o = sys_reg.init_drive;
    ack_o = link_reg.ack;
    ack_oe_o = link_reg.ack_drive;
    dout_o = dout_reg;
    config_done_o = sys_reg.done;
  end

endmodule

// file: logic/sync_parallel_config_loader_regs.svh
// Constants for the slave-parallel configuration loader
`ifndef SYNC_PARALLEL_CONFIG_LOADER_REGS_SVH
`define SYNC_PARALLEL_CONFIG_LOADER_REGS_SVH

// Mode-select code, most significant pin first
`define MODE_SLAVE_PARALLEL 3'h3

// Bit position of the last bit within a byte
`define BYTE_LAST_BIT 3'h7
`define BYTE_FIRST_BIT 3'h0

// Serial stream layout, counted in bits leaving the shifter
`define BIT_CNT_W 16
`define PREAMBLE_BITS 16'h0010
`define OWN_CONFIG_BITS 16'h0100
`define BIT_CNT_ONE 16'h0001
`define BIT_CNT_ZERO 16'h0000

// Memory-clear time after reset, in system clock cycles
`define CLEAR_CNT_W 12
`define INIT_CLEAR_CYCLES 12'h040
`define CLEAR_CNT_ONE 12'h001
`define CLEAR_CNT_ZERO 12'h000

// Idle level of the daisy-chain output while bits are consumed
`define DOUT_IDLE 1'b1

`endif

// file: logic/sync_parallel_config_loader_pkg.sv
// Types for the slave-parallel configuration loader
package sync_parallel_config_loader_pkg;

  typedef enum logic [1:0] {
    SYS_CLEAR,
    SYS_WAIT_MODE,
    SYS_LOADING,
    SYS_DONE
  } sys_state_t;

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_PREAMBLE,
    LINK_OWN,
    LINK_FORWARD
  } link_state_t;

  typedef struct packed {
    sys_state_t state;
    logic [2:0] mode_meta;
    logic [2:0] mode_sync;
    logic init_meta;
    logic init_sync;
    logic [11:0] clear_cnt;
    logic init_drive;
    logic load_en;
    logic done_meta;
    logic done_sync;
    logic done;
  } sys_regs_t;

  typedef struct packed {
    link_state_t state;
    logic en_meta;
    logic en_sync;
    logic started;
    logic [2:0] phase;
    logic [7:0] shift;
    logic [15:0] bit_cnt;
    logic ser_bit;
    logic ack;
    logic ack_drive;
    logic loaded;
  } link_regs_t;

endpackage

// file: verif/spcl_props.sv
// Port checker for the configuration loader
`timescale 1ns/1ps
module spcl_props (
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic config_clock_i,
  // Pins
  input wire logic mode_select_msb_i,
  input wire logic mode_select_mid_i,
  input wire logic mode_select_lsb_i,
  input wire logic init_i,
  input wire logic init_o,
  input wire logic init_oe_o,
  input wire logic [7:0] data_i,
  input wire logic ack_o,
  input wire logic ack_oe_o,
  input wire logic dout_o,
  input wire logic config_done_o
);
  // Byte index within the stream and the daisy-chain level seen at each rising edge
  logic [5:0] idx_reg = 6'h00;
  logic hold_reg = 1'b1;
  wire fwd = idx_reg < 6'h02 || idx_reg > 6'h21;
  always_ff @(posedge config_clock_i) begin
    hold_reg <= dout_o;
    if (!ack_oe_o) idx_reg <= 6'h00;
    else if (ack_o && idx_reg != 6'h3f) idx_reg <= idx_reg + 6'h01;
  end
  sequence quiet7;
    !ack_o [*7];
  endsequence
  // First two bits of a forwarded byte, 1.5 periods after capture, MSB first
  sequence first_two_bits;
    dout_o == $past(data_i[7], 2) ##1 dout_o == $past(data_i[6], 3);
  endsequence
  ack_pulse_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i) ack_o |=> !ack_o)
    else $error("ack too long");
  ack_gap_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i) ack_o |=> quiet7)
    else $error("ack too soon");
  ack_driven_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i) ack_o |-> ack_oe_o)
    else $error("ack undriven");
  mode_gate_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i)
    ({mode_select_msb_i, mode_select_mid_i, mode_select_lsb_i} != 3'h3) [*8] |-> !ack_oe_o)
    else $error("load outside mode");
  fwd_bits_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i) ack_o && fwd
    |=> first_two_bits)
    else $error("dout bit wrong");
  own_bits_a: assert property (@(posedge config_clock_i) disable iff (!rst_n_i) ack_o && !fwd |=> dout_o [*8])
    else $error("own bit leaked");
  dout_fall_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    config_clock_i && ack_oe_o |-> dout_o == hold_reg)
    else $error("dout moved high");
  init_od_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) init_oe_o |-> !init_o)
    else $error("init driven high");
endmodule
bind sync_parallel_config_loader spcl_props u_props (.*);

// file: verif/cfg_ctrl_model.sv
// Controller model: makes the link clock, feeds bytes and samples the daisy chain
`timescale 1ns/1ps
module cfg_ctrl_model (
  // Link side
  output logic config_clock_o,
  output logic [7:0] data_o,
  input wire logic ack_i,
  input wire logic dout_i
);
  logic [7:0] tx_q[$];
  logic rx_q[$];
  int acks = 0;
  initial begin
    config_clock_o = 1'b0;
    forever #24 config_clock_o = ~config_clock_o;
  end
  initial data_o = 8'h00;
  task automatic stream(input int trail);
    int ph = -1;
    int e = -1;
    int last = -1;
    data_o = tx_q.pop_front();
    for (int i = 0; i < 2000 && (last < 0 || i < last + trail); i++) begin
      @(posedge config_clock_o);
      if (e >= 0) e++;
      if (e >= 2) rx_q.push_back(dout_i);
      #1;
      // Acknowledge paces the test and is counted in acks
      if (ack_i === 1'b1) begin
        acks++;
        ph = 0;
        if (e < 0) e = 0;
        if (tx_q.size() == 0 && last < 0) last = i;
      end
      @(negedge config_clock_o);
      if (ph >= 0) ph++;
      // Noise on the ignored edges
      if (ph == 8 && tx_q.size() != 0) data_o = tx_q.pop_front();
      else if (ph >= 0) data_o = ~data_o;
    end
  endtask
endmodule

// file: verif/tb_sync_parallel_config_loader.sv
// Testbench for the configuration loader
`timescale 1ns/1ps
`include "sync_parallel_config_loader_regs.svh"
module tb_sync_parallel_config_loader;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ext_rel = 1'b0;
  logic [2:0] mode = 3'h0;
  logic cfg_clk, init_o, init_oe_o, ack_o, ack_oe_o, dout_o, done;
  logic [7:0] data;
  int failures = 0;
  int num_checks = 0;
  // Init wire held low from outside until ext_rel, then pulled up; ack pin weakly pulled up
  wire init_wire = !init_oe_o && ext_rel;
  wire ack_pin = ack_oe_o ? ack_o : 1'b1;
  sync_parallel_config_loader DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .config_clock_i(cfg_clk),
    .mode_select_msb_i(mode[2]), .mode_select_mid_i(mode[1]), .mode_select_lsb_i(mode[0]), .init_i(init_wire),
    .init_o(init_o), .init_oe_o(init_oe_o), .data_i(data), .ack_o(ack_o), .ack_oe_o(ack_oe_o),
    .dout_o(dout_o), .config_done_o(done));
  cfg_ctrl_model ctrl (.config_clock_o(cfg_clk), .data_o(data), .ack_i(ack_o), .dout_i(dout_o));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [7:0] pat(input int i);
    return 8'h3c + 8'(i * 37);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_init();
    check({init_oe_o, init_o, done}, 3'h4);
    rst_n_i = 1'b1;
    repeat (`INIT_CLEAR_CYCLES - 2) @(negedge sys_clk_i);
    check({init_oe_o, ack_oe_o, ack_pin}, 3'h5);
    repeat (4) @(negedge sys_clk_i);
    check({init_oe_o, init_o}, 2'h0);
  endtask
  task automatic t_modes();
    mode = 3'h3;
    repeat (30) @(negedge sys_clk_i);
    check(ack_oe_o, 1'b0);
    ext_rel = 1'b1;
    for (int m = 0; m < 8; m++) if (m != 3) begin
      mode = 3'(m);
      repeat (30) @(negedge sys_clk_i);
      check({ack_oe_o, ack_pin}, 2'h1);
    end
  endtask
  task automatic t_stream();
    logic [7:0] b;
    logic e;
    for (int i = 0; i < 36; i++) ctrl.tx_q.push_back(pat(i));
    mode = 3'h3;
    ctrl.stream(11);
    check(ctrl.acks >= 36, 1'b1);
    check(ctrl.rx_q.size() >= 288, 1'b1);
    for (int n = 0; n < 288 && n < ctrl.rx_q.size(); n++) begin
      b = pat(n / 8);
      e = (n < 16 || n >= 272) ? b[7 - n % 8] : 1'b1;
      check(ctrl.rx_q[n], e);
    end
    @(negedge sys_clk_i);
    check(done, 1'b1);
    mode = 3'h0;
    for (int i = 0; i < 400 && ack_oe_o !== 1'b0; i++) @(negedge sys_clk_i);
    check(ack_oe_o, 1'b0);
  endtask
  initial begin
    repeat (3) @(negedge sys_clk_i);
    t_init();
    t_modes();
    t_stream();
    give_verdict();
  end
endmodule
